// ==== inc/piofs_pkg.sv ====
// Constants, register map and types for the pulse I/O terminal function select block.
// Assumes a 25 MHz APB clock; all times below are turned into cycles from that rate.
package piofs_pkg;
  localparam int CLK_MHZ = 25;
  localparam int FILTER_STEP_US = 500;
  localparam int FILTER_STEP_CYC = FILTER_STEP_US * CLK_MHZ;
  localparam int REFRESH_US = 1000;
  localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
  localparam int NUM_IN = 10;
  localparam int NUM_OUT = 6;
  localparam int MAX_IRQ_IN = 4;
  localparam int MAX_PWM = 2;
  localparam int NUM_AXES = 2;
  localparam int CW = 16;

  // Register byte offsets
  localparam logic [11:0] ADDR_IN_CFG = 12'h000;
  localparam logic [11:0] ADDR_OUT_CFG = 12'h004;
  localparam logic [11:0] ADDR_OUT_IMAGE = 12'h008;
  localparam logic [11:0] ADDR_IN_IMAGE = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_CMP01 = 12'h010;
  localparam logic [11:0] ADDR_IRQ_CMP23 = 12'h014;
  localparam logic [11:0] ADDR_PG0 = 12'h018;
  localparam logic [11:0] ADDR_PG1 = 12'h01C;
  localparam logic [11:0] ADDR_CMD = 12'h020;
  localparam logic [11:0] ADDR_PWM0 = 12'h024;
  localparam logic [11:0] ADDR_PWM1 = 12'h028;
  localparam logic [11:0] ADDR_HSC_CNT = 12'h02C;
  localparam logic [11:0] ADDR_HSC_TGT = 12'h030;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h034;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h038;
  localparam logic [11:0] ADDR_CONFLICT = 12'h03C;

  // Input configuration fields
  localparam int F_IRQ_EN = 0;
  localparam int F_IRQ_CNTMODE = 4;
  localparam int F_IRQ_OFFEDGE = 8;
  localparam int F_HSC_EN = 12;
  localparam int F_ORG_EN = 14;
  localparam int F_ORG_NOPROX = 16;
  localparam int F_FILTER = 18;
  localparam int F_FILTER_W = 3;
  // Output configuration fields
  localparam int F_PG_EN = 0;
  localparam int F_PWM_EN = 2;
  // Command register fields
  localparam int F_CMD_PG_START = 0;
  localparam int F_CMD_ORG_START = 2;
  localparam int F_CMD_STOP = 4;
  // Interrupt status fields
  localparam int S_IRQ_IN = 0;
  localparam int S_HSC = 4;
  localparam int S_PG_DONE = 6;
  localparam int S_ORG_DONE = 8;
  localparam int NUM_STATUS = 10;

  // Input terminal use per axis: origin, proximity, counter Z, phase A, phase B
  localparam int T_ORG [NUM_AXES] = '{0, 2};
  localparam int T_PROX [NUM_AXES] = '{1, 3};
  localparam int T_HSC_Z [NUM_AXES] = '{3, 2};
  localparam int T_HSC_A [NUM_AXES] = '{8, 6};
  localparam int T_HSC_B [NUM_AXES] = '{9, 7};
  // Output terminal use: pulse outputs then PWM outputs
  localparam int T_PG_OUT [NUM_AXES] = '{0, 1};
  localparam int T_PWM_OUT [MAX_PWM] = '{4, 5};

  localparam logic [31:0] RST_IN_CFG = 32'h0000_0000;
  localparam logic [9:0] RST_IRQ_MASK = 10'h000;

  typedef enum logic [2:0] {
    PIOFS_PG_IDLE = 3'b001,
    PIOFS_PG_HIGH = 3'b010,
    PIOFS_PG_LOW = 3'b100
  } piofs_pg_state_type;

  typedef enum logic [2:0] {
    PIOFS_OS_IDLE = 3'b001,
    PIOFS_OS_PROX = 3'b010,
    PIOFS_OS_ORG = 3'b100
  } piofs_os_state_type;
endpackage

// ==== inc/piofs_pg_if.sv ====
// Link between the terminal selector and one fixed-duty pulse generator.
// The controller side drives the request; the generator side reports progress.
`timescale 1ns/10ps
interface piofs_pg_if;
  logic start;
  logic stop;
  logic cont;
  logic [15:0] half;
  logic [15:0] count;
  logic busy;
  logic pulse;
  logic done;
  modport ctrl (output start, stop, cont, half, count, input busy, pulse, done);
  modport gen (input start, stop, cont, half, count, output busy, pulse, done);
endinterface

// ==== core/piofs_pulse_gen.sv ====
// Fixed 50% duty pulse generator: a burst of count pulses, or a free run.
// Assumes start is a one-cycle strobe from the selector, ignored while busy.
`timescale 1ns/10ps
module piofs_pulse_gen
  import piofs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  piofs_pg_if.gen pg
);
  typedef struct packed {
    piofs_pg_state_type st;
    logic [15:0] hp;
    logic [15:0] tcnt;
    logic [15:0] left;
    logic cont;
    logic pulse;
    logic done;
  } piofs_pgs_type;

  piofs_pgs_type r_reg;
  piofs_pgs_type r_next;

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    case (r_reg.st)
      PIOFS_PG_IDLE: begin
        // A zero half period or an empty burst cannot be served and is ignored
        if (pg.start && pg.half != 16'h0000 && (pg.cont || pg.count != 16'h0000)) begin
          r_next.st = PIOFS_PG_HIGH;
          r_next.hp = pg.half;
          r_next.left = pg.count;
          r_next.cont = pg.cont;
          r_next.tcnt = 16'h0000;
          r_next.pulse = 1'b1;
        end
      end
      PIOFS_PG_HIGH: begin
        if (pg.stop) begin
          r_next.st = PIOFS_PG_IDLE;
          r_next.pulse = 1'b0;
          r_next.done = 1'b1;
        end else if (r_reg.tcnt == r_reg.hp - 16'h0001) begin
          r_next.tcnt = 16'h0000;
          r_next.st = PIOFS_PG_LOW;
          r_next.pulse = 1'b0;
        end else begin
          r_next.tcnt = r_reg.tcnt + 16'h0001;
        end
      end
      PIOFS_PG_LOW: begin
        if (pg.stop) begin
          r_next.st = PIOFS_PG_IDLE;
          r_next.done = 1'b1;
        end else if (r_reg.tcnt == r_reg.hp - 16'h0001) begin
          r_next.tcnt = 16'h0000;
          if (!r_reg.cont && r_reg.left == 16'h0001) begin
            r_next.st = PIOFS_PG_IDLE;
            r_next.done = 1'b1;
          end else begin
            r_next.st = PIOFS_PG_HIGH;
            r_next.pulse = 1'b1;
            if (!r_reg.cont) begin
              r_next.left = r_reg.left - 16'h0001;
            end
          end
        end else begin
          r_next.tcnt = r_reg.tcnt + 16'h0001;
        end
      end
      default: begin
        r_next.st = PIOFS_PG_IDLE;
        r_next.pulse = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '{st: PIOFS_PG_IDLE, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign pg.busy = (r_reg.st != PIOFS_PG_IDLE);
  assign pg.pulse = r_reg.pulse;
  assign pg.done = r_reg.done;
endmodule

// ==== core/piofs_top.sv ====
// Terminal function selector of one pulse I/O expansion module, with APB registers.
// Assumes field inputs are already synchronous to pclk; one module of a two-module system.
//
// Behaviour
// - At most two PWM outputs per module, four per controller.
// - Plain inputs enter the input image only at periodic refresh.
// - Direct interrupt fires on the configured on or off transition.
// - Counter interrupt fires when counted transitions equal the programmed value.
// - Positioning output gives exactly N pulses at set frequency, 50% duty.
// - PWM output high fraction equals programmed duty setting.
// - High-speed counter input counts edges and can raise interrupts.
// - Plain output drives its image level, updated at refresh instants.
// - Origin search pulses until proximity then origin input end it.
// - Each terminal carries one function; software must not double-allocate.
// - Multi-terminal functions block others needing those terminals.
// - Input priority: origin search, then counter Z/reset, then plain/interrupt.
// - Shared input filter: none, 0.5, 1, 2, 4, 8, 16, 32 ms.
// - At most four interrupt inputs, direct or counter mode.
`timescale 1ns/10ps
module piofs_top
  import piofs_pkg::*;
#(
  parameter int FILTER_TICK_CYCLES = FILTER_STEP_CYC,
  parameter int REFRESH_CYCLES = REFRESH_CYC,
  parameter int PWM_CH = MAX_PWM,
  parameter int IRQ_INPUTS = MAX_IRQ_IN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_IN-1:0] in_term,
  output logic [NUM_OUT-1:0] out_term,
  output logic irq
);
  if (PWM_CH < 1 || PWM_CH > MAX_PWM) begin : g_bad_pwm
    $error("PWM_CH must be 1 or 2");
  end
  if (IRQ_INPUTS < 1 || IRQ_INPUTS > MAX_IRQ_IN) begin : g_bad_irq
    $error("IRQ_INPUTS must be 1 to 4");
  end
  if (FILTER_TICK_CYCLES < 1 || REFRESH_CYCLES < 1) begin : g_bad_time
    $error("tick counts must be positive");
  end

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] in_cfg;
    logic [3:0] out_cfg;
    logic [NUM_OUT-1:0] out_image;
    logic [NUM_OUT-1:0] out_latch;
    logic [NUM_OUT-1:0] out_pins;
    logic [NUM_IN-1:0] in_image;
    logic [NUM_IN-1:0] last_in;
    logic [3:0][CW-1:0] irq_cmp;
    logic [3:0][CW-1:0] irq_cnt;
    logic [1:0][CW-1:0] pg_half;
    logic [1:0][CW-1:0] pg_count;
    logic [1:0] pg_go;
    logic [1:0] pg_cont;
    logic [1:0] pg_stop;
    logic [1:0][CW-1:0] pwm_per;
    logic [1:0][CW-1:0] pwm_high;
    logic [1:0][CW-1:0] pwm_cnt;
    logic [1:0][CW-1:0] hsc_cnt;
    logic [1:0][CW-1:0] hsc_tgt;
    logic [1:0][2:0] os_st;
    logic [NUM_STATUS-1:0] irq_status;
    logic [NUM_STATUS-1:0] irq_mask;
    logic irq;
    logic [NUM_IN-1:0] conflict;
    logic [31:0] ref_cnt;
    logic [31:0] ftick_cnt;
    logic [NUM_IN-1:0][6:0] filt_cnt;
    logic [NUM_IN-1:0] filt_val;
  } piofs_state_type;

  piofs_state_type r_reg;
  piofs_state_type r_next;

  piofs_pg_if pg0 ();
  piofs_pg_if pg1 ();
  logic [1:0] pg_busy;
  logic [1:0] pg_pulse;
  logic [1:0] pg_done;

  piofs_pulse_gen u_pg0 (.pclk(pclk), .presetn(presetn), .pg(pg0.gen));
  piofs_pulse_gen u_pg1 (.pclk(pclk), .presetn(presetn), .pg(pg1.gen));

  assign pg0.start = r_reg.pg_go[0];
  assign pg0.stop = r_reg.pg_stop[0];
  assign pg0.cont = r_reg.pg_cont[0];
  assign pg0.half = r_reg.pg_half[0];
  assign pg0.count = r_reg.pg_count[0];
  assign pg1.start = r_reg.pg_go[1];
  assign pg1.stop = r_reg.pg_stop[1];
  assign pg1.cont = r_reg.pg_cont[1];
  assign pg1.half = r_reg.pg_half[1];
  assign pg1.count = r_reg.pg_count[1];
  assign pg_busy = {pg1.busy, pg0.busy};
  assign pg_pulse = {pg1.pulse, pg0.pulse};
  assign pg_done = {pg1.done, pg0.done};

  // Settling time in filter steps: 0 means no filter, else 2^(sel-1) steps of 0.5 ms
  function automatic logic [6:0] filt_limit(input logic [2:0] sel);
    filt_limit = (sel == 3'h0) ? 7'h00 : (7'h01 << (sel - 3'h1));
  endfunction

  function automatic logic [31:0] pack2(input logic [CW-1:0] hi, input logic [CW-1:0] lo);
    pack2 = {hi, lo};
  endfunction

  logic [NUM_IN-1:0] org_own;
  logic [NUM_IN-1:0] z_own;
  logic [NUM_IN-1:0] hsc_own;
  logic [NUM_IN-1:0] irq_own;
  logic [NUM_IN-1:0] plain_own;
  logic [NUM_IN-1:0] rise;
  logic [NUM_IN-1:0] fall;
  logic [NUM_STATUS-1:0] st_set;
  logic [NUM_STATUS-1:0] st_clr;
  logic [NUM_OUT-1:0] drive;
  logic wr_acc;
  logic rd_acc;
  logic ref_tick;
  logic f_tick;

  always_comb begin
    r_next = r_reg;
    org_own = '0;
    z_own = '0;
    hsc_own = '0;
    irq_own = '0;
    st_set = '0;
    st_clr = '0;
    r_next.pg_go = 2'b00;
    r_next.pg_stop = 2'b00;
    rise = in_term & ~r_reg.last_in;
    fall = ~in_term & r_reg.last_in;
    r_next.last_in = in_term;

    // Ownership of input terminals, highest priority first
    for (int a = 0; a < NUM_AXES; a++) begin
      if (r_reg.in_cfg[F_ORG_EN + a]) begin
        org_own[T_ORG[a]] = 1'b1;
        org_own[T_PROX[a]] = 1'b1;
      end
    end
    for (int a = 0; a < NUM_AXES; a++) begin
      if (r_reg.in_cfg[F_HSC_EN + a]) begin
        hsc_own[T_HSC_A[a]] = 1'b1;
        hsc_own[T_HSC_B[a]] = 1'b1;
        z_own[T_HSC_Z[a]] = ~org_own[T_HSC_Z[a]];
      end
    end
    for (int i = 0; i < IRQ_INPUTS; i++) begin
      irq_own[i] = r_reg.in_cfg[F_IRQ_EN + i] & ~org_own[i] & ~z_own[i];
    end
    plain_own = ~(org_own | z_own | hsc_own | irq_own);
    r_next.conflict = '0;
    for (int a = 0; a < NUM_AXES; a++) begin
      r_next.conflict[T_HSC_Z[a]] = r_reg.in_cfg[F_HSC_EN + a] & org_own[T_HSC_Z[a]];
    end
    for (int i = 0; i < IRQ_INPUTS; i++) begin
      r_next.conflict[i] = r_next.conflict[i] |
        (r_reg.in_cfg[F_IRQ_EN + i] & (org_own[i] | z_own[i]));
    end

    // Shared noise filter and refresh timing
    f_tick = (r_reg.ftick_cnt == 32'(FILTER_TICK_CYCLES - 1));
    r_next.ftick_cnt = f_tick ? 32'h0000_0000 : r_reg.ftick_cnt + 32'h0000_0001;
    ref_tick = (r_reg.ref_cnt == 32'(REFRESH_CYCLES - 1));
    r_next.ref_cnt = ref_tick ? 32'h0000_0000 : r_reg.ref_cnt + 32'h0000_0001;
    for (int i = 0; i < NUM_IN; i++) begin
      if (in_term[i] == r_reg.filt_val[i]) begin
        r_next.filt_cnt[i] = 7'h00;
      end else if (r_reg.filt_cnt[i] >= filt_limit(r_reg.in_cfg[F_FILTER +: F_FILTER_W])) begin
        r_next.filt_val[i] = in_term[i];
        r_next.filt_cnt[i] = 7'h00;
      end else if (f_tick) begin
        r_next.filt_cnt[i] = r_reg.filt_cnt[i] + 7'h01;
      end
    end
    if (ref_tick) begin
      r_next.in_image = r_reg.filt_val & plain_own;
      r_next.out_latch = r_reg.out_image;
    end

    // Interrupt inputs, direct or counter mode
    for (int i = 0; i < IRQ_INPUTS; i++) begin
      if (irq_own[i] && (r_reg.in_cfg[F_IRQ_OFFEDGE + i] ? fall[i] : rise[i])) begin
        if (!r_reg.in_cfg[F_IRQ_CNTMODE + i]) begin
          st_set[S_IRQ_IN + i] = 1'b1;
        end else if (r_reg.irq_cnt[i] + 16'h0001 >= r_reg.irq_cmp[i]) begin
          st_set[S_IRQ_IN + i] = 1'b1;
          r_next.irq_cnt[i] = '0;
        end else begin
          r_next.irq_cnt[i] = r_reg.irq_cnt[i] + 16'h0001;
        end
      end
    end

    // High-speed counters: phase A edge counts, phase B level gives direction
    for (int a = 0; a < NUM_AXES; a++) begin
      if (r_reg.in_cfg[F_HSC_EN + a]) begin
        if (z_own[T_HSC_Z[a]] && rise[T_HSC_Z[a]]) begin
          r_next.hsc_cnt[a] = '0;
        end else if (rise[T_HSC_A[a]]) begin
          r_next.hsc_cnt[a] = in_term[T_HSC_B[a]] ? r_reg.hsc_cnt[a] - 16'h0001
                                                  : r_reg.hsc_cnt[a] + 16'h0001;
          if (r_next.hsc_cnt[a] == r_reg.hsc_tgt[a]) begin
            st_set[S_HSC + a] = 1'b1;
          end
        end
      end
    end

    // Origin search: free-running pulses until proximity, then origin
    for (int a = 0; a < NUM_AXES; a++) begin
      case (r_reg.os_st[a])
        PIOFS_OS_PROX: begin
          if (r_reg.in_cfg[F_ORG_NOPROX + a] || rise[T_PROX[a]]) begin
            r_next.os_st[a] = PIOFS_OS_ORG;
          end
        end
        PIOFS_OS_ORG: begin
          if (in_term[T_ORG[a]]) begin
            r_next.pg_stop[a] = 1'b1;
            r_next.os_st[a] = PIOFS_OS_IDLE;
            st_set[S_ORG_DONE + a] = 1'b1;
          end
        end
        default: r_next.os_st[a] = PIOFS_OS_IDLE;
      endcase
      if (r_reg.os_st[a] != PIOFS_OS_IDLE && !r_reg.in_cfg[F_ORG_EN + a]) begin
        r_next.pg_stop[a] = 1'b1;
        r_next.os_st[a] = PIOFS_OS_IDLE;
      end
      if (pg_done[a] && r_reg.os_st[a] == PIOFS_OS_IDLE) begin
        st_set[S_PG_DONE + a] = 1'b1;
      end
    end

    // PWM timebase
    for (int p = 0; p < PWM_CH; p++) begin
      if (r_reg.out_cfg[F_PWM_EN + p] && r_reg.pwm_cnt[p] + 16'h0001 < r_reg.pwm_per[p]) begin
        r_next.pwm_cnt[p] = r_reg.pwm_cnt[p] + 16'h0001;
      end else begin
        r_next.pwm_cnt[p] = '0;
      end
    end

    // Output terminals: a claimed pin never shows the plain image
    drive = r_reg.out_latch;
    for (int a = 0; a < NUM_AXES; a++) begin
      if (r_reg.out_cfg[F_PG_EN + a]) begin
        drive[T_PG_OUT[a]] = pg_pulse[a];
      end
    end
    for (int p = 0; p < PWM_CH; p++) begin
      if (r_reg.out_cfg[F_PWM_EN + p]) begin
        drive[T_PWM_OUT[p]] = (r_reg.pwm_cnt[p] < r_reg.pwm_high[p]);
      end
    end
    r_next.out_pins = drive;

    // APB slave: read data ready with pready, writes land at the completing edge
    wr_acc = psel & penable & r_reg.pready & pwrite;
    rd_acc = psel & penable & ~r_reg.pready;
    r_next.pready = rd_acc;
    if (rd_acc && !pwrite) begin
      r_next.pslverr = 1'b0;
      r_next.prdata = 32'h0000_0000;
      if (paddr == ADDR_IN_CFG) begin
        r_next.prdata = r_reg.in_cfg;
      end else if (paddr == ADDR_OUT_CFG) begin
        r_next.prdata = {28'h000_0000, r_reg.out_cfg};
      end else if (paddr == ADDR_OUT_IMAGE) begin
        r_next.prdata = {26'h000_0000, r_reg.out_image};
      end else if (paddr == ADDR_IN_IMAGE) begin
        r_next.prdata = {22'h00_0000, r_reg.in_image};
      end else if (paddr == ADDR_IRQ_CMP01) begin
        r_next.prdata = pack2(r_reg.irq_cmp[1], r_reg.irq_cmp[0]);
      end else if (paddr == ADDR_IRQ_CMP23) begin
        r_next.prdata = pack2(r_reg.irq_cmp[3], r_reg.irq_cmp[2]);
      end else if (paddr == ADDR_PG0) begin
        r_next.prdata = pack2(r_reg.pg_count[0], r_reg.pg_half[0]);
      end else if (paddr == ADDR_PG1) begin
        r_next.prdata = pack2(r_reg.pg_count[1], r_reg.pg_half[1]);
      end else if (paddr == ADDR_CMD) begin
        r_next.prdata = {28'h000_0000, r_reg.os_st[1] != PIOFS_OS_IDLE,
                         r_reg.os_st[0] != PIOFS_OS_IDLE, pg_busy};
      end else if (paddr == ADDR_PWM0) begin
        r_next.prdata = pack2(r_reg.pwm_high[0], r_reg.pwm_per[0]);
      end else if (paddr == ADDR_PWM1) begin
        r_next.prdata = pack2(r_reg.pwm_high[1], r_reg.pwm_per[1]);
      end else if (paddr == ADDR_HSC_CNT) begin
        r_next.prdata = pack2(r_reg.hsc_cnt[1], r_reg.hsc_cnt[0]);
      end else if (paddr == ADDR_HSC_TGT) begin
        r_next.prdata = pack2(r_reg.hsc_tgt[1], r_reg.hsc_tgt[0]);
      end else if (paddr == ADDR_IRQ_STATUS) begin
        r_next.prdata = {22'h00_0000, r_reg.irq_status};
      end else if (paddr == ADDR_IRQ_MASK) begin
        r_next.prdata = {22'h00_0000, r_reg.irq_mask};
      end else if (paddr == ADDR_CONFLICT) begin
        r_next.prdata = {22'h00_0000, r_reg.conflict};
      end else begin
        r_next.pslverr = 1'b1;
      end
    end
    if (wr_acc) begin
      if (paddr == ADDR_IN_CFG) begin
        r_next.in_cfg = pwdata;
      end else if (paddr == ADDR_OUT_CFG) begin
        r_next.out_cfg = pwdata[3:0];
      end else if (paddr == ADDR_OUT_IMAGE) begin
        r_next.out_image = pwdata[NUM_OUT-1:0];
      end else if (paddr == ADDR_IRQ_CMP01) begin
        r_next.irq_cmp[0] = pwdata[15:0];
        r_next.irq_cmp[1] = pwdata[31:16];
      end else if (paddr == ADDR_IRQ_CMP23) begin
        r_next.irq_cmp[2] = pwdata[15:0];
        r_next.irq_cmp[3] = pwdata[31:16];
      end else if (paddr == ADDR_PG0 && !pg_busy[0]) begin
        r_next.pg_half[0] = pwdata[15:0];
        r_next.pg_count[0] = pwdata[31:16];
      end else if (paddr == ADDR_PG1 && !pg_busy[1]) begin
        r_next.pg_half[1] = pwdata[15:0];
        r_next.pg_count[1] = pwdata[31:16];
      end else if (paddr == ADDR_CMD) begin
        for (int a = 0; a < NUM_AXES; a++) begin
          // Pulse and origin use share one generator, so each waits for the other
          if (!pg_busy[a] && r_reg.out_cfg[F_PG_EN + a] && r_reg.os_st[a] == PIOFS_OS_IDLE) begin
            if (pwdata[F_CMD_ORG_START + a] && r_reg.in_cfg[F_ORG_EN + a]) begin
              r_next.pg_go[a] = 1'b1;
              r_next.pg_cont[a] = 1'b1;
              r_next.os_st[a] = PIOFS_OS_PROX;
            end else if (pwdata[F_CMD_PG_START + a]) begin
              r_next.pg_go[a] = 1'b1;
              r_next.pg_cont[a] = 1'b0;
            end
          end
          if (pwdata[F_CMD_STOP + a]) begin
            r_next.pg_stop[a] = 1'b1;
            r_next.pg_go[a] = 1'b0;
            r_next.os_st[a] = PIOFS_OS_IDLE;
          end
        end
      end else if (paddr == ADDR_PWM0) begin
        r_next.pwm_per[0] = pwdata[15:0];
        r_next.pwm_high[0] = pwdata[31:16];
      end else if (paddr == ADDR_PWM1 && PWM_CH > 1) begin
        r_next.pwm_per[1] = pwdata[15:0];
        r_next.pwm_high[1] = pwdata[31:16];
      end else if (paddr == ADDR_HSC_TGT) begin
        r_next.hsc_tgt[0] = pwdata[15:0];
        r_next.hsc_tgt[1] = pwdata[31:16];
      end else if (paddr == ADDR_IRQ_STATUS) begin
        st_clr = pwdata[NUM_STATUS-1:0];
      end else if (paddr == ADDR_IRQ_MASK) begin
        r_next.irq_mask = pwdata[NUM_STATUS-1:0];
      end
    end
    // A new event in the clearing cycle is kept
    r_next.irq_status = (r_reg.irq_status & ~st_clr) | st_set;
    r_next.irq = |(r_next.irq_status & r_next.irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_reg <= '0;
      r_reg.in_cfg <= RST_IN_CFG;
      r_reg.irq_mask <= RST_IRQ_MASK;
      r_reg.os_st <= {PIOFS_OS_IDLE, PIOFS_OS_IDLE};
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign out_term = r_reg.out_pins;
  assign irq = r_reg.irq;
endmodule

// ==== test/piofs_field_model.sv ====
// Field side of the selector: encoder on IN8/IN9, pulse drive on OUT0, lamp on OUT4.
// Assumes the bench strobes enc_go for one cycle and keeps lvl[9:8] low meanwhile.
`timescale 1ns/10ps
module piofs_field_model
  import piofs_pkg::*;
(
  input wire logic pclk,
  input wire logic [NUM_IN-1:0] lvl,
  input wire logic enc_go,
  input wire logic [7:0] enc_n,
  input wire logic enc_dir,
  input wire logic [NUM_OUT-1:0] out_term,
  output logic [NUM_IN-1:0] in_term,
  output int drv_pulses,
  output int lamp_hi
);
  logic [9:0] ph = 10'h000;
  logic prev0 = 1'h0;
  int pulses_seen = 0, lamp_seen = 0;
  assign drv_pulses = pulses_seen;
  assign lamp_hi = lamp_seen;
  // Four cycles per step keeps phase A at a quarter of the counter's sampling rate
  assign in_term = {enc_dir | lvl[9], ph[1] | lvl[8], lvl[7:0]};
  always @(posedge pclk) begin
    ph <= enc_go ? {enc_n, 2'h0} : ((ph != 10'h000) ? ph - 10'h001 : ph);
    prev0 <= out_term[0];
    if (out_term[0] && !prev0) pulses_seen <= pulses_seen + 1;
    if (out_term[4]) lamp_seen <= lamp_seen + 1;
  end
endmodule

// ==== test/piofs_top_properties.sv ====
// Checker for the selector's APB slave and interrupt pin.
// Assumes it is bound onto piofs_top and sees its ports only.
`timescale 1ns/10ps
module piofs_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq
);
  logic wr_done;
  assign wr_done = pready && pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held past one cycle");
  chk_ready_after_enable: assert property (psel && penable && !$past(penable) |=> pready)
    else $error("pready not one cycle after access start");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  chk_err_on_read: assert property ($changed(pslverr) |-> pready && !pwrite)
    else $error("pslverr moved outside a read");
  chk_data_on_read: assert property ($changed(prdata) |-> pready && !pwrite)
    else $error("prdata moved outside a read");
  chk_unmapped_err: assert property (pready && !pwrite && paddr > 12'h03C |-> pslverr && prdata == 32'h0)
    else $error("unmapped read not refused");
  chk_mapped_ok: assert property (pready && !pwrite && paddr <= 12'h03C |-> !pslverr)
    else $error("mapped read flagged as error");
  // A stuck status bit can only be dropped by software, never by the field side
  chk_irq_clear: assert property ($fell(irq) |-> $past(wr_done) || $past(wr_done, 2))
    else $error("irq dropped without a register write");
endmodule
bind piofs_top piofs_top_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .irq(irq));

// ==== test/tb_top.sv ====
// Register-level bench for the terminal selector with a field-side model.
// Assumes short filter and refresh parameters; every transfer goes over APB.
`timescale 1ns/10ps
module tb_top;
  import piofs_pkg::*;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic enc_go = 1'h0, enc_dir = 1'h0, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [NUM_IN-1:0] lvl = 10'h000, in_term;
  logic [NUM_OUT-1:0] out_term;
  logic [7:0] enc_n = 8'h00;
  int miscompares = 0, samples_checked = 0, cyc = 0, base, drv_pulses, lamp_hi;
  always #20 pclk = ~pclk;
  piofs_top #(.FILTER_TICK_CYCLES(4), .REFRESH_CYCLES(8)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_term(in_term),
    .out_term(out_term), .irq(irq));
  piofs_field_model field_u (.pclk(pclk), .lvl(lvl), .enc_go(enc_go), .enc_n(enc_n),
    .enc_dir(enc_dir), .out_term(out_term), .in_term(in_term), .drv_pulses(drv_pulses),
    .lamp_hi(lamp_hi));
  task automatic test_done;
    $display("compared %0d, mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Starts on an edge of its own, so back-to-back calls never drive psel twice at once
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic chk_rd(input string nm, input logic [11:0] a, input logic [31:0] m,
      input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    cmp(nm, e, rd & m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      miscompares++;
      test_done;
    end
  end
  initial begin
    tick(12);
    presetn <= 1'h1;
    chk_rd("in_cfg_rst", ADDR_IN_CFG, 32'hFFFF_FFFF, RST_IN_CFG);
    chk_rd("mask_rst", ADDR_IRQ_MASK, 32'h3FF, 32'(RST_IRQ_MASK));
    chk_rd("unmapped", 12'hFFC, 32'hFFFF_FFFF, 32'h0);
    cmp("slverr", 32'h1, 32'(pslverr));
    lvl <= 10'h0A5;
    tick(20);
    chk_rd("in_image", ADDR_IN_IMAGE, 32'h3FF, 32'h0A5);
    xfer(1'h1, ADDR_OUT_IMAGE, 32'h2A);
    tick(20);
    cmp("out_term", 32'h2A, 32'(out_term));
    lvl <= 10'h000;
    xfer(1'h1, ADDR_IRQ_MASK, 32'h3FF);
    xfer(1'h1, ADDR_IN_CFG, 32'h23);
    xfer(1'h1, ADDR_IRQ_CMP01, 32'h0003_0000);
    lvl <= 10'h001;
    tick(20);
    cmp("irq_pin", 32'h1, 32'(irq));
    chk_rd("in0_owned", ADDR_IN_IMAGE, 32'h1, 32'h0);
    chk_rd("direct_irq", ADDR_IRQ_STATUS, 32'h3FF, 32'h1);
    xfer(1'h1, ADDR_IRQ_STATUS, 32'h3FF);
    tick(3);
    cmp("irq_clear", 32'h0, 32'(irq));
    for (int i = 1; i <= 3; i++) begin
      lvl <= 10'h003;
      tick(3);
      lvl <= 10'h001;
      tick(3);
      chk_rd("count_irq", ADDR_IRQ_STATUS, 32'h2, (i == 3) ? 32'h2 : 32'h0);
    end
    xfer(1'h1, ADDR_IRQ_STATUS, 32'h3FF);
    xfer(1'h1, ADDR_PG0, 32'h0003_0002);
    xfer(1'h1, ADDR_PWM0, 32'h0003_0008);
    xfer(1'h1, ADDR_OUT_CFG, 32'h5);
    base = drv_pulses;
    xfer(1'h1, ADDR_CMD, 32'h1);
    tick(40);
    cmp("pulses", 32'h3, 32'(drv_pulses - base));
    chk_rd("burst_done", ADDR_IRQ_STATUS, 32'h40, 32'h40);
    base = lamp_hi;
    tick(32);
    cmp("pwm_high", 32'hC, 32'(lamp_hi - base));
    xfer(1'h1, ADDR_IN_CFG, 32'h1000);
    xfer(1'h1, ADDR_HSC_TGT, 32'h5);
    xfer(1'h1, ADDR_IRQ_STATUS, 32'h3FF);
    enc_n <= 8'h05;
    enc_go <= 1'h1;
    tick(1);
    enc_go <= 1'h0;
    tick(30);
    chk_rd("hsc_count", ADDR_HSC_CNT, 32'hFFFF, 32'h5);
    chk_rd("hsc_hit", ADDR_IRQ_STATUS, 32'h10, 32'h10);
    xfer(1'h1, ADDR_IN_CFG, 32'hA004);
    xfer(1'h1, ADDR_IRQ_STATUS, 32'h3FF);
    lvl <= 10'h005;
    tick(10);
    chk_rd("in2_lost", ADDR_IRQ_STATUS, 32'h4, 32'h0);
    xfer(1'h0, ADDR_CONFLICT, 32'h0);
    cmp("conflict", 32'h4, rd);
    xfer(1'h1, ADDR_PG1, 32'h2);
    xfer(1'h1, ADDR_OUT_CFG, 32'h2);
    xfer(1'h1, ADDR_CMD, 32'h8);
    chk_rd("org_run", ADDR_CMD, 32'hA, 32'hA);
    lvl <= 10'h00D;
    tick(4);
    chk_rd("org_done", ADDR_IRQ_STATUS, 32'h200, 32'h200);
    test_done;
  end
endmodule
